/* core/sfm_pkg.sv */
package sfm_pkg;
  // Register byte offsets
  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_MAXLEN  = 4'h4;
  localparam logic [3:0] ADDR_MASK    = 4'h8;
  localparam logic [3:0] ADDR_STATUS  = 4'hc;
  // Control fields and reset values
  localparam int         CTRL_MODE_BIT   = 0;
  localparam logic       CTRL_RESET      = 1'h0;
  localparam logic [15:0] MAXLEN_RESET   = 16'h0110;
  localparam logic [6:0] MASK_RESET      = 7'h7f;
  // Interrupt mask bit positions
  localparam int MSK_MATCH = 0;
  localparam int MSK_SHORT = 1;
  localparam int MSK_ALIGN = 2;
  localparam int MSK_CHECK = 3;
  localparam int MSK_LONG  = 4;
  localparam int MSK_UP    = 5;
  localparam int MSK_DOWN  = 6;
  // Status field positions
  localparam int ST_ERRCNT_LSB = 0;
  localparam int ST_BAD_LSB   = 8;
  localparam int ST_GOOD_LSB  = 16;
  localparam int ST_FILT_BIT  = 24;
  localparam int ST_OCTM_BIT  = 25;
  // Golden message limits, in octets except GOLD_BITS, which is in bits
  localparam int CHECK_OCTETS   = 2;
  localparam int GOLD_MIN_PAY   = 3;
  localparam int GOLD_MAX_PAY   = 5;
  localparam int GOLD_MIN_OCT   = GOLD_MIN_PAY + CHECK_OCTETS;
  localparam int GOLD_MAX_OCT   = GOLD_MAX_PAY + CHECK_OCTETS;
  localparam int GOLD_BITS      = GOLD_MAX_OCT * 8;
  // Monitor counter widths
  localparam int ERRCNT_W = 6;
  localparam int BAD_W   = 4;
  localparam int GOOD_W  = 8;
endpackage : sfm_pkg

/* core/sfm_rx_monitor.sv */
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module sfm_rx_monitor #(
  parameter int MAXLEN_W = 16
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_b_in,
  // Receive path from the deframer, same clock
  input  wire logic        rx_frame_start_in,
  input  wire logic        rx_bit_valid_in,
  input  wire logic        rx_bit_in,
  input  wire logic        rx_octet_in,
  input  wire logic        rx_frame_end_in,
  input  wire logic        rx_abort_in,
  input  wire logic        short_frame_error_in,
  input  wire logic        align_error_in,
  input  wire logic        check_error_in,
  // Register port
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  // Buffer side
  output logic             store_msg_out,
  output logic             discard_msg_out,
  output logic             filter_active_out,
  // Events toward the interrupt queue
  output logic             filter_match_interrupt_out,
  output logic             short_frame_error_out,
  output logic             align_error_interrupt_out,
  output logic             check_error_interrupt_out,
  output logic             long_frame_error_interrupt_out,
  output logic             error_count_up_interrupt_out,
  output logic             error_count_down_interrupt_out
);

  localparam int SW = sfm_pkg::ERRCNT_W;
  localparam logic [SW-1:0] ERRCNT_MAX = '1;

  logic                        signalling_hdlc_16bit_check_mode;
  logic [MAXLEN_W-1:0]         max_len;
  logic [6:0]                  irq_mask;
  logic                        filter_mode;
  logic [sfm_pkg::GOLD_BITS-1:0] golden;
  logic [sfm_pkg::GOLD_BITS-1:0] capture;
  logic [7:0]                  gold_bits;
  logic [7:0]                  bit_cnt;
  logic [MAXLEN_W-1:0]         oct_cnt;
  logic                        mismatch;
  logic                        long_err;
  logic                        octet_mode;
  logic [sfm_pkg::BAD_W-1:0]   bad_cnt;
  logic [sfm_pkg::GOOD_W-1:0]  good_cnt;
  logic [SW-1:0]               signal_unit_error_rate_counter;
  logic [SW-1:0]               next_error_rate;
  logic                        evt_match;
  logic                        evt_short;
  logic                        evt_align;
  logic                        evt_check;
  logic                        evt_long;
  logic                        evt_up;
  logic                        evt_down;

  ////////////////////////////////////////////////////////////////////////////
  // Frame classification
  logic error_free;
  logic good_end;
  logic qualifies;
  logic bit_miss;
  logic long_now;
  logic bad_wrap;
  logic good_wrap;
  logic [2:0] inc_n;

  assign error_free = !short_frame_error_in && !align_error_in &&
                      !check_error_in && !long_err;
  assign good_end   = rx_frame_end_in && error_free;
  // Payload 3..5 plus two check octets, whole octets only
  assign qualifies  = good_end &&
                      oct_cnt >= MAXLEN_W'(sfm_pkg::GOLD_MIN_OCT) &&
                      oct_cnt <= MAXLEN_W'(sfm_pkg::GOLD_MAX_OCT) &&
                      bit_cnt == 8'(oct_cnt * 8);
  // Longer than golden, or a differing bit
  assign bit_miss   = filter_mode && !mismatch && rx_bit_valid_in &&
                      (bit_cnt >= gold_bits ||
                       golden[bit_cnt[5:0]] != rx_bit_in);
  assign long_now   = rx_octet_in && !long_err &&
                      oct_cnt >= max_len;
  assign bad_wrap   = octet_mode && rx_octet_in &&
                      bad_cnt == '1;
  assign good_wrap  = good_end && good_cnt == '1;
  assign inc_n      = 3'(short_frame_error_in && rx_frame_end_in) +
                      3'(align_error_in && rx_frame_end_in) +
                      3'(check_error_in && rx_frame_end_in) +
                      3'(bad_wrap);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      signalling_hdlc_16bit_check_mode <= sfm_pkg::CTRL_RESET;
      max_len  <= MAXLEN_W'(sfm_pkg::MAXLEN_RESET);
      irq_mask <= sfm_pkg::MASK_RESET;
    end else if (reg_wr_in) begin
      if (reg_addr_in == sfm_pkg::ADDR_CTRL) begin
        signalling_hdlc_16bit_check_mode <=
          reg_wdata_in[sfm_pkg::CTRL_MODE_BIT];
      end else if (reg_addr_in == sfm_pkg::ADDR_MAXLEN) begin
        max_len <= reg_wdata_in[MAXLEN_W-1:0];
      end else if (reg_addr_in == sfm_pkg::ADDR_MASK) begin
        irq_mask <= reg_wdata_in[6:0];
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 32'h0;
    end else if (!reg_rd_in) begin
      reg_rdata_out <= 32'h0;
    end else if (reg_addr_in == sfm_pkg::ADDR_CTRL) begin
      reg_rdata_out <= 32'(signalling_hdlc_16bit_check_mode);
    end else if (reg_addr_in == sfm_pkg::ADDR_MAXLEN) begin
      reg_rdata_out <= 32'(max_len);
    end else if (reg_addr_in == sfm_pkg::ADDR_MASK) begin
      reg_rdata_out <= 32'(irq_mask);
    end else if (reg_addr_in == sfm_pkg::ADDR_STATUS) begin
      reg_rdata_out <=
        (32'(signal_unit_error_rate_counter) << sfm_pkg::ST_ERRCNT_LSB) |
        (32'(bad_cnt)     << sfm_pkg::ST_BAD_LSB) |
        (32'(good_cnt)    << sfm_pkg::ST_GOOD_LSB) |
        (32'(filter_mode) << sfm_pkg::ST_FILT_BIT) |
        (32'(octet_mode)  << sfm_pkg::ST_OCTM_BIT);
    end else begin
      reg_rdata_out <= 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-frame bookkeeping
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bit_cnt  <= 8'h0;
      oct_cnt  <= '0;
      capture  <= '0;
      mismatch <= 1'b0;
      long_err <= 1'b0;
    end else if (rx_frame_start_in || rx_abort_in || rx_frame_end_in) begin
      bit_cnt  <= 8'h0;
      oct_cnt  <= '0;
      mismatch <= 1'b0;
      long_err <= 1'b0;
    end else begin
      if (rx_bit_valid_in) begin
        if (bit_cnt < 8'(sfm_pkg::GOLD_BITS)) begin
          capture[bit_cnt[5:0]] <= rx_bit_in;
        end
        if (bit_cnt != 8'hff) begin
          bit_cnt <= bit_cnt + 8'h1;
        end
      end
      if (rx_octet_in && oct_cnt != '1) begin
        oct_cnt <= oct_cnt + 1'b1;
      end
      if (bit_miss) begin
        mismatch <= 1'b1;
      end
      if (long_now) begin
        long_err <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Message filtering
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      filter_mode     <= 1'b0;
      golden          <= '0;
      gold_bits       <= 8'h0;
      store_msg_out   <= 1'b0;
      discard_msg_out <= 1'b0;
      evt_match       <= 1'b0;
    end else begin
      store_msg_out   <= 1'b0;
      discard_msg_out <= 1'b0;
      evt_match       <= 1'b0;
      if (!signalling_hdlc_16bit_check_mode) begin
        filter_mode <= 1'b0;
        store_msg_out <= rx_frame_end_in;
      end else if (bit_miss) begin
        filter_mode <= 1'b0;
      end else if (rx_frame_end_in && filter_mode && !mismatch &&
                   bit_cnt == gold_bits) begin
        evt_match       <= 1'b1;
        discard_msg_out <= 1'b1;
      end else if (rx_frame_end_in) begin
        store_msg_out <= 1'b1;
        filter_mode   <= qualifies;
        if (qualifies) begin
          golden    <= capture;
          gold_bits <= bit_cnt;
        end
      end
    end
  end

  assign filter_active_out = filter_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Bad-octet and good-message counters
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      octet_mode <= 1'b0;
      bad_cnt    <= '0;
    end else if (!octet_mode && (rx_abort_in || long_now)) begin
      octet_mode <= 1'b1;
      bad_cnt    <= '0;
    end else if (octet_mode && good_end) begin
      octet_mode <= 1'b0;
    end else if (octet_mode && rx_octet_in) begin
      bad_cnt <= bad_cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      good_cnt <= '0;
    end else if (good_end) begin
      good_cnt <= good_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Leaky-bucket error rate counter
  always_comb begin
    logic [SW+2:0] sum;
    sum = (SW+3)'(signal_unit_error_rate_counter) + (SW+3)'(inc_n);
    if (good_wrap && sum != '0) begin
      sum = sum - (SW+3)'(1);
    end
    if (sum > (SW+3)'(ERRCNT_MAX)) begin
      next_error_rate = ERRCNT_MAX;
    end else begin
      next_error_rate = sum[SW-1:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      signal_unit_error_rate_counter <= '0;
      evt_up   <= 1'b0;
      evt_down <= 1'b0;
    end else begin
      signal_unit_error_rate_counter <= next_error_rate;
      evt_up   <= next_error_rate > signal_unit_error_rate_counter;
      evt_down <= next_error_rate < signal_unit_error_rate_counter;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      evt_short <= 1'b0;
      evt_align <= 1'b0;
      evt_check <= 1'b0;
      evt_long  <= 1'b0;
    end else begin
      evt_short <= rx_frame_end_in && short_frame_error_in;
      evt_align <= rx_frame_end_in && align_error_in;
      evt_check <= rx_frame_end_in && check_error_in;
      evt_long  <= long_now;
    end
  end

  assign filter_match_interrupt_out =
    evt_match && irq_mask[sfm_pkg::MSK_MATCH];
  assign short_frame_error_out = evt_short && irq_mask[sfm_pkg::MSK_SHORT];
  assign align_error_interrupt_out = evt_align && irq_mask[sfm_pkg::MSK_ALIGN];
  assign check_error_interrupt_out = evt_check && irq_mask[sfm_pkg::MSK_CHECK];
  assign long_frame_error_interrupt_out =
    evt_long && irq_mask[sfm_pkg::MSK_LONG];
  assign error_count_up_interrupt_out = evt_up && irq_mask[sfm_pkg::MSK_UP];
  assign error_count_down_interrupt_out =
    evt_down && irq_mask[sfm_pkg::MSK_DOWN];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_good_end;
    rx_frame_end_in && error_free;
  endsequence
  sequence s_bad_wrap;
    octet_mode && rx_octet_in && bad_cnt == '1;
  endsequence

  property p_mode_forces_off;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    !signalling_hdlc_16bit_check_mode |=> !filter_mode;
  endproperty
  a_mode_forces_off: assert property (p_mode_forces_off)
    else $error("filtering active outside signalling mode");
  property p_enter_with_store;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    $rose(filter_mode) |-> store_msg_out &&
      gold_bits <= 8'(sfm_pkg::GOLD_BITS) &&
      gold_bits >= 8'(sfm_pkg::GOLD_MIN_OCT * 8);
  endproperty
  a_enter_with_store: assert property (p_enter_with_store)
    else $error("filter entered without storing a qualifying message");
  property p_match_keeps;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    evt_match |-> filter_mode && !store_msg_out && discard_msg_out &&
      $stable(golden);
  endproperty
  a_match_keeps: assert property (p_match_keeps)
    else $error("match did not keep filtering and golden");
  property p_mismatch_exits;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    bit_miss |=> !filter_mode;
  endproperty
  a_mismatch_exits: assert property (p_mismatch_exits)
    else $error("mismatch did not leave filtering");
  property p_bad_wrap_raises;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    s_bad_wrap ##0 (!good_wrap && signal_unit_error_rate_counter != ERRCNT_MAX)
      |=> evt_up;
  endproperty
  a_bad_wrap_raises: assert property (p_bad_wrap_raises)
    else $error("bad octet wrap did not raise error counter");
  property p_entry_clears;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    $rose(octet_mode) |-> bad_cnt == '0;
  endproperty
  a_entry_clears: assert property (p_entry_clears)
    else $error("bad octet counter not cleared on entry");
  property p_exit_on_good;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    octet_mode ##1 !octet_mode |-> $past(good_end);
  endproperty
  a_exit_on_good: assert property (p_exit_on_good)
    else $error("bad octet mode left without a good message");

  property p_good_frozen;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    octet_mode && !good_end |=> $stable(good_cnt);
  endproperty
  a_good_frozen: assert property (p_good_frozen)
    else $error("good counter moved in bad octet mode");

  property p_up_changes;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    evt_up |-> signal_unit_error_rate_counter >
               $past(signal_unit_error_rate_counter);
  endproperty
  a_up_changes: assert property (p_up_changes)
    else $error("count up event without increment");

  property p_down_on_wrap;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    s_good_end ##0 (good_cnt == '1 && inc_n == 3'h0 &&
                    signal_unit_error_rate_counter != '0)
      |=> evt_down && signal_unit_error_rate_counter ==
          $past(signal_unit_error_rate_counter) - 1'b1;
  endproperty
  a_down_on_wrap: assert property (p_down_on_wrap)
    else $error("good counter wrap did not lower error counter");

  property p_no_wrap_at_max;
    @(posedge core_clk_in) disable iff (!rst_b_in)
    signal_unit_error_rate_counter == ERRCNT_MAX && !good_wrap
      |=> signal_unit_error_rate_counter == ERRCNT_MAX && !evt_down;
  endproperty
  a_no_wrap_at_max: assert property (p_no_wrap_at_max)
    else $error("error counter wrapped past maximum");

endmodule : sfm_rx_monitor

/* verification/sfm_line_model.sv */
`timescale 1ns/1ps
module sfm_line_model (
  input  wire logic clk_in,
  output logic      frame_start_out,
  output logic      bit_valid_out,
  output logic      bit_out,
  output logic      octet_out,
  output logic      frame_end_out,
  output logic      abort_out,
  output logic [2:0] err_out
);
  logic bit_d;
  logic tog;
  // Line shows a changing pattern whenever no bit is offered
  assign bit_out = bit_valid_out ? bit_d : tog;
  initial begin
    {frame_start_out, bit_valid_out, octet_out} = 3'h0;
    {frame_end_out, abort_out, err_out, bit_d, tog} = 7'h00;
  end
  always @(posedge clk_in) begin
    tog <= ~tog;
  end
  // Frame: start, n octets LSB first, then closing flag or abort
  task send(input logic [55:0] data, input int n, input logic [2:0] err,
            input logic abort);
    int i;
    @(posedge clk_in);
    frame_start_out <= 1'b1;
    @(posedge clk_in);
    frame_start_out <= 1'b0;
    for (i = 0; i < n * 8; i++) begin
      bit_valid_out <= 1'b1;
      bit_d         <= data[i % 56];
      octet_out     <= (i % 8 == 7);
      @(posedge clk_in);
    end
    bit_valid_out <= 1'b0;
    octet_out     <= 1'b0;
    frame_end_out <= ~abort;
    abort_out     <= abort;
    err_out       <= abort ? 3'h0 : err;
    @(posedge clk_in);
    {frame_end_out, abort_out, err_out} <= 5'h00;
    repeat (3) @(posedge clk_in);
  endtask : send
endmodule : sfm_line_model

/* verification/tb_ss7_receive_filter_and_error_monitor.sv */
`timescale 1ns/1ps
module tb_ss7_receive_filter_and_error_monitor;
  logic        core_clk_in;
  logic        rst_b_in;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  wire  [31:0] reg_rdata;
  wire         fs, bv, bt, oc, fe, ab, filt_act;
  wire  [2:0]  err;
  wire  [8:0]  ev;
  int          ev_cnt[9] = '{default: 0};
  int          ev_exp[9] = '{default: 0};
  int          errors = 0;
  int          checked = 0;
  int          sexp = 0;
  int          gexp = 0;
  int          s_base = 0;
  logic [31:0] v;
  localparam logic [55:0] A = 56'h5544332211;
  localparam logic [55:0] B = 56'h77665544332211;

  sfm_line_model u_line (.clk_in(core_clk_in), .frame_start_out(fs),
    .bit_valid_out(bv), .bit_out(bt), .octet_out(oc), .frame_end_out(fe),
    .abort_out(ab), .err_out(err));

  sfm_rx_monitor DUT (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
    .rx_frame_start_in(fs), .rx_bit_valid_in(bv), .rx_bit_in(bt),
    .rx_octet_in(oc), .rx_frame_end_in(fe), .rx_abort_in(ab),
    .short_frame_error_in(err[0]), .align_error_in(err[1]),
    .check_error_in(err[2]), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .store_msg_out(ev[0]),
    .discard_msg_out(ev[1]), .filter_active_out(filt_act),
    .filter_match_interrupt_out(ev[2]), .short_frame_error_out(ev[3]),
    .align_error_interrupt_out(ev[4]), .check_error_interrupt_out(ev[5]),
    .long_frame_error_interrupt_out(ev[6]),
    .error_count_up_interrupt_out(ev[7]),
    .error_count_down_interrupt_out(ev[8]));

  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end

  // Event pulses last one cycle; tally them
  always @(posedge core_clk_in) begin
    for (int k = 0; k < 9; k++) if (ev[k] === 1'b1) ev_cnt[k] <= ev_cnt[k] + 1;
  end

  ////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk_in);
    reg_wr    <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk_in);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk_in);
    reg_rd   <= 1'b0;
    @(negedge core_clk_in);
    d = reg_rdata;
  endtask : rd

  // Good frame: advances the good count, wrap lowers the error counter
  task gf(input logic [55:0] d, input int n);
    u_line.send(d, n, 3'h0, 1'b0);
    gexp = (gexp + 1) % 256;
    if (gexp == 0 && sexp > 0) begin
      sexp--;
      ev_exp[8]++;
    end
  endtask : gf

  task bf(input logic [55:0] d, input int n, input logic [2:0] e);
    u_line.send(d, n, e, 1'b0);
  endtask : bf

  task st_chk(input logic octm, input logic filt, input int bexp);
    logic [31:0] e;
    logic [31:0] m;
    rd(sfm_pkg::ADDR_STATUS, v);
    e = {6'h0, octm, filt, 8'(gexp), 4'h0, 4'(bexp), 2'h0, 6'(sexp)};
    m = (bexp < 0) ? 32'hfffff0ff : 32'hffffffff;
    check(v & m, e & m);
  endtask : st_chk

  task ev_chk;
    for (int k = 1; k < 9; k++) check(32'(ev_cnt[k]), 32'(ev_exp[k]));
  endtask : ev_chk

  task sto(input int d);
    check(32'(ev_cnt[0] - s_base), 32'(d));
    s_base = ev_cnt[0];
  endtask : sto

  task stop_test;
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge core_clk_in);
    errors++;
    stop_test;
  end

  initial begin
    rst_b_in  = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (2) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    rd(sfm_pkg::ADDR_CTRL, v);
    check(v, 32'h0);
    rd(sfm_pkg::ADDR_MAXLEN, v);
    check(v, 32'h00000110);
    rd(sfm_pkg::ADDR_MASK, v);
    check(v, 32'h0000007f);
    rd(4'h2, v);
    check(v, 32'h0);
    st_chk(1'b0, 1'b0, 0);
    // Mode off: a full good-count wrap at zero leaves the counter alone
    for (int i = 0; i < 256; i++) gf(A, 1);
    st_chk(1'b0, 1'b0, 0);
    ev_chk;
    gf(A, 5);
    st_chk(1'b0, 1'b0, 0);
    sto(257);
    wr(sfm_pkg::ADDR_CTRL, 32'h1);
    gf(A, 5);
    check(32'(filt_act), 32'h1);
    st_chk(1'b0, 1'b1, 0);
    sto(1);
    gf(A, 5);
    ev_exp[1]++;
    ev_exp[2]++;
    st_chk(1'b0, 1'b1, 0);
    ev_chk;
    gf(B, 7);
    sto(1);
    gf(B, 7);
    ev_exp[1]++;
    ev_exp[2]++;
    st_chk(1'b0, 1'b1, 0);
    ev_chk;
    gf(B, 8);
    st_chk(1'b0, 1'b0, 0);
    gf(B, 8);
    st_chk(1'b0, 1'b0, 0);
    sto(2);
    gf(A, 5);
    gf(A ^ 56'h1, 5);
    st_chk(1'b0, 1'b1, 0);
    sto(2);
    // Each error kind raises its own event and the counter
    for (int k = 0; k < 3; k++) begin
      bf(A, 5, 3'(1 << k));
      ev_exp[3 + k]++;
      ev_exp[7]++;
      sexp++;
    end
    st_chk(1'b0, 1'b0, 0);
    ev_chk;
    wr(sfm_pkg::ADDR_MASK, 32'h0);
    bf(A, 5, 3'h1);
    sexp++;
    ev_chk;
    wr(sfm_pkg::ADDR_MASK, 32'h7f);
    // Abort enters octet mode; sixteen bad octets raise the counter
    u_line.send(A, 0, 3'h0, 1'b1);
    st_chk(1'b1, 1'b0, 0);
    bf(A, 16, 3'h4);
    ev_exp[5]++;
    ev_exp[7] += 2;
    sexp += 2;
    bf(A, 5, 3'h4);
    ev_exp[5]++;
    ev_exp[7]++;
    sexp++;
    st_chk(1'b1, 1'b0, 5);
    ev_chk;
    gf(A, 1);
    st_chk(1'b0, 1'b0, -1);
    // Over-length message enters octet mode with a cleared counter
    wr(sfm_pkg::ADDR_MAXLEN, 32'h4);
    bf(A, 5, 3'h0);
    ev_exp[6]++;
    st_chk(1'b1, 1'b0, 0);
    ev_chk;
    wr(sfm_pkg::ADDR_MAXLEN, 32'h110);
    gf(A, 1);
    st_chk(1'b0, 1'b0, -1);
    // Check errors drive the counter to its ceiling, where it stays
    for (int i = 0; i < 60; i++) begin
      bf(A, 1, 3'h4);
      ev_exp[5]++;
      if (sexp < 63) begin
        sexp++;
        ev_exp[7]++;
      end
    end
    st_chk(1'b0, 1'b0, -1);
    ev_chk;
    while (gexp != 0) gf(A, 1);
    st_chk(1'b0, 1'b0, -1);
    ev_chk;
    stop_test;
  end
endmodule : tb_ss7_receive_filter_and_error_monitor
